// File: test/pcg_gating_bank_tb.sv
// Purpose: Self-checking bench for the peripheral clock gating bank over classic Wishbone.
// Assumes: Answer one cycle after a request is taken; gates follow writes within two edges.
// Notes:   Bit groups are rebuilt from the gate outputs so they compare against register words.
module pcg_gating_bank_tb import pcg_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic         clk = 1'b0;
  logic         rst_n = 1'b0;
  logic         cyc = 1'b0;
  logic         stb = 1'b0;
  logic         we = 1'b0;
  logic [11:0]  adr = 12'h000;
  logic [3:0]   sel = 4'hF;
  logic [31:0]  dat = 32'h0000_0000;
  logic [31:0]  rdat;
  logic         ack, err, grant, fault, irq;
  logic         ua = 1'b0;
  logic [3:0]   usel = 4'h0;
  pcg_mode_type mode = PCG_RUN;
  logic         cmp, t2, t1, t0, twi, syn, a1, a0, pe, pd, pc, pb, pa;
  wire  [31:0]  g1 = {7'h0, cmp, 5'h0, t2, t1, t0, 3'h0, twi, 7'h0, syn, 2'h0, a1, a0};
  wire  [31:0]  g2 = {27'h0, pe, pd, pc, pb, pa};
  int           errors = 0;
  int           tests_run = 0;
  logic [31:0]  rv;
  logic         ev;
  logic [11:0]  offs [6] = '{RUN_ONE_OFF, RUN_TWO_OFF, SLEEP_ONE_OFF, SLEEP_TWO_OFF,
                             DEEP_ONE_OFF, DEEP_TWO_OFF};
  logic [31:0]  vals [6] = '{32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'h0001_0001, 32'h0000_0005,
                             32'h0100_0010, 32'h0000_000A};
  int           pos [8] = '{0, 1, 4, 12, 16, 17, 18, 24};

  pcg_gating_bank pcg_gating_bank_i (.CLK_IN(clk), .RST_N_IN(rst_n), .WB_CYC_IN(cyc),
    .WB_STB_IN(stb), .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(dat),
    .WB_DAT_OUT(rdat), .WB_ACK_OUT(ack), .WB_ERR_OUT(err), .POWER_MODE_IN(mode),
    .UNIT_ACCESS_IN(ua), .UNIT_SEL_IN(usel), .UNIT_GRANT_OUT(grant), .UNIT_FAULT_OUT(fault),
    .ANALOG_COMPARATOR_ZERO_GATE_OUT(cmp), .GENERAL_TIMER_TWO_GATE_OUT(t2),
    .GENERAL_TIMER_ONE_GATE_OUT(t1), .GENERAL_TIMER_ZERO_GATE_OUT(t0), .TWO_WIRE_GATE_OUT(twi),
    .SYNCHRONOUS_SERIAL_GATE_OUT(syn), .ASYNC_SERIAL_SECOND_GATE_OUT(a1),
    .ASYNC_SERIAL_FIRST_GATE_OUT(a0), .IO_BANK_E_GATE_OUT(pe), .IO_BANK_D_GATE_OUT(pd),
    .IO_BANK_C_GATE_OUT(pc), .IO_BANK_B_GATE_OUT(pb), .IO_BANK_A_GATE_OUT(pa), .IRQ_OUT(irq));

  // Free-running system clock, 8 ns period.
  always #4 clk = ~clk;

  // Counts every comparison and reports a mismatch at once.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  // Single place where the run ends.
  task automatic report_and_stop();
    $display("tests_run=%0d errors=%0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // One classic cycle; the request holds until ack or err is sampled, bounded by a timeout.
  task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d,
                    output logic [31:0] r, output logic e);
    int n;
    n = 0;
    r = 32'h0;
    e = 1'b0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    while (n < 20) begin
      @(posedge clk);
      if (ack === 1'b1 || err === 1'b1) begin
        r = rdat;
        e = err;
        break;
      end
      n++;
    end
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n == 20) begin
      errors++;
      report_and_stop();
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    wb(1'b1, a, d, rv, ev);
    check({31'h0, ev}, 32'h0);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0, rv, ev);
    check({31'h0, ev}, 32'h0);
    check(rv, exp);
  endtask

  // Lets register and mode changes reach the gate outputs before they are sampled.
  task automatic settle();
    repeat (3) @(posedge clk);
    #1;
  endtask

  // One unit access attempt; the answer is sampled in the cycle after it is taken.
  task automatic acc(input logic [3:0] u, input logic g);
    @(posedge clk);
    ua   <= 1'b1;
    usel <= u;
    @(posedge clk);
    ua <= 1'b0;
    #1;
    check({30'h0, grant, fault}, {30'h0, g, ~g});
  endtask

  // Main sequence: reset state, register map, mode selection, access checks, interrupt.
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    check(g1 | g2, 32'h0);
    for (int i = 0; i < 6; i++) rd(offs[i], GATE_RESET);
    acc(UNIT_ASYNC0, 1'b0);
    rd(IRQ_STATUS_OFF, 32'h0000_0001);
    for (int i = 0; i < 6; i++) wr(offs[i], vals[i]);
    for (int i = 0; i < 6; i++) begin
      rd(offs[i], vals[i] & ((i % 2 == 0) ? GROUP_ONE_MASK : GROUP_TWO_MASK));
    end
    settle();
    check(g1, GROUP_ONE_MASK);
    check(g2, GROUP_TWO_MASK);
    @(posedge clk);
    mode <= PCG_SLEEP;
    settle();
    check(g1, GROUP_ONE_MASK);
    wr(RUN_CFG_OFF, 32'h0000_0001);
    settle();
    check(g1, 32'h0001_0001);
    check(g2, 32'h0000_0005);
    @(posedge clk);
    mode <= PCG_DEEP;
    settle();
    check(g1, 32'h0100_0010);
    check(g2, 32'h0000_000A);
    for (int u = 0; u < 13; u++) acc(u[3:0], (u < 8) ? vals[4][pos[u]] : vals[5][u - 8]);
    // Last faulted unit is bank E, the final unclocked unit tried above.
    rd(FAULT_UNIT_OFF, {28'h000_0000, UNIT_BANK_E});
    // Byte lane zero only: the upper lanes of the sleep word must keep their bits.
    sel <= 4'h1;
    wr(SLEEP_ONE_OFF, 32'hFFFF_FFFF);
    sel <= 4'hF;
    rd(SLEEP_ONE_OFF, 32'h0001_0013);
    // Unmapped words answer with an error, both ways.
    wb(1'b1, 12'h300, 32'hFFFF_FFFF, rv, ev);
    check({31'h0, ev}, 32'h1);
    wb(1'b0, 12'h300, 32'h0, rv, ev);
    check({31'h0, ev}, 32'h1);
    check(rv, 32'h0);
    check({31'h0, irq}, 32'h0);
    wr(IRQ_MASK_OFF, 32'h0000_0001);
    settle();
    check({31'h0, irq}, 32'h1);
    wr(IRQ_STATUS_OFF, 32'h0000_0003);
    settle();
    check({31'h0, irq}, 32'h0);
    report_and_stop();
  end
endmodule

// File: verilog/pcg_gate_select.sv
// Purpose: Pick the gating word set that applies in the current operating mode.
// Assumes: Word and auto-gate inputs are registered copies held in the register bank; mode_in comes straight from the port.
// Notes:   Pure combinational; the caller registers the result.
module pcg_gate_select
  import pcg_pkg::*;
(
  input  wire pcg_pkg::pcg_mode_type mode_in,
  input  wire logic                  auto_gate_in,
  input  wire logic [31:0]           run_one_in,
  input  wire logic [31:0]           run_two_in,
  input  wire logic [31:0]           sleep_one_in,
  input  wire logic [31:0]           sleep_two_in,
  input  wire logic [31:0]           deep_one_in,
  input  wire logic [31:0]           deep_two_in,
  output logic      [31:0]           eff_one_out,
  output logic      [31:0]           eff_two_out
);

  import pcg_pkg::*;

  // Low-power copies only apply when automatic gating is chosen; else run enables stay.
  always_comb begin
    eff_one_out = run_one_in;
    eff_two_out = run_two_in;
    case (mode_in)
      PCG_RUN: begin
        eff_one_out = run_one_in;
        eff_two_out = run_two_in;
      end
      PCG_SLEEP: begin
        if (auto_gate_in) begin
          eff_one_out = sleep_one_in;
          eff_two_out = sleep_two_in;
        end
      end
      PCG_DEEP: begin
        if (auto_gate_in) begin
          eff_one_out = deep_one_in;
          eff_two_out = deep_two_in;
        end
      end
      default: begin
        eff_one_out = run_one_in;
        eff_two_out = run_two_in;
      end
    endcase
  end

endmodule

// File: verilog/pcg_gating_bank.sv
// Purpose: Per-unit clock enables from two groups of run, sleep and deep-sleep gating words.
// Assumes: Classic Wishbone master; POWER_MODE_IN and unit access checks are synchronous.
// Notes:   Gate outputs are clock enables for downstream gating cells, one per unit.
//
// Register access over Wishbone was decided locally.
module pcg_gating_bank
  import pcg_pkg::*;
(
  input  wire logic                  CLK_IN,
  input  wire logic                  RST_N_IN,
  input  wire logic                  WB_CYC_IN,
  input  wire logic                  WB_STB_IN,
  input  wire logic                  WB_WE_IN,
  input  wire logic [11:0]           WB_ADR_IN,
  input  wire logic [3:0]            WB_SEL_IN,
  input  wire logic [31:0]           WB_DAT_IN,
  output logic      [31:0]           WB_DAT_OUT,
  output logic                       WB_ACK_OUT,
  output logic                       WB_ERR_OUT,
  input  wire pcg_pkg::pcg_mode_type POWER_MODE_IN,
  input  wire logic                  UNIT_ACCESS_IN,
  input  wire logic [3:0]            UNIT_SEL_IN,
  output logic                       UNIT_GRANT_OUT,
  output logic                       UNIT_FAULT_OUT,
  output logic                       ANALOG_COMPARATOR_ZERO_GATE_OUT,
  output logic                       GENERAL_TIMER_TWO_GATE_OUT,
  output logic                       GENERAL_TIMER_ONE_GATE_OUT,
  output logic                       GENERAL_TIMER_ZERO_GATE_OUT,
  output logic                       TWO_WIRE_GATE_OUT,
  output logic                       SYNCHRONOUS_SERIAL_GATE_OUT,
  output logic                       ASYNC_SERIAL_SECOND_GATE_OUT,
  output logic                       ASYNC_SERIAL_FIRST_GATE_OUT,
  output logic                       IO_BANK_E_GATE_OUT,
  output logic                       IO_BANK_D_GATE_OUT,
  output logic                       IO_BANK_C_GATE_OUT,
  output logic                       IO_BANK_B_GATE_OUT,
  output logic                       IO_BANK_A_GATE_OUT,
  output logic                       IRQ_OUT
);

  import pcg_pkg::*;

  // Merge write data into a register under byte enables and a writable-bit mask.
  function automatic logic [31:0] merge_write(input logic [31:0] old_val,
                                              input logic [31:0] new_val,
                                              input logic [3:0]  sel,
                                              input logic [31:0] wmask);
    logic [31:0] lane;
    lane = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    merge_write = (old_val & ~(lane & wmask)) | (new_val & lane & wmask);
  endfunction

  // Word-aligned address match.
  function automatic logic addr_hit(input logic [11:0] adr, input logic [11:0] off);
    addr_hit = (adr[11:2] == off[11:2]);
  endfunction

  // Look up whether a unit's clock is currently running.
  function automatic logic unit_on(input logic [3:0]  unit,
                                   input logic [31:0] one,
                                   input logic [31:0] two);
    case (unit)
      UNIT_ASYNC0: unit_on = one[ASYNC0_BIT];
      UNIT_ASYNC1: unit_on = one[ASYNC1_BIT];
      UNIT_SYNC:   unit_on = one[SYNC_BIT];
      UNIT_TWI:    unit_on = one[TWI_BIT];
      UNIT_TIMER0: unit_on = one[TIMER0_BIT];
      UNIT_TIMER1: unit_on = one[TIMER1_BIT];
      UNIT_TIMER2: unit_on = one[TIMER2_BIT];
      UNIT_CMP_ZERO: unit_on = one[CMP_ZERO_BIT];
      UNIT_BANK_A: unit_on = two[BANK_A_BIT];
      UNIT_BANK_B: unit_on = two[BANK_B_BIT];
      UNIT_BANK_C: unit_on = two[BANK_C_BIT];
      UNIT_BANK_D: unit_on = two[BANK_D_BIT];
      UNIT_BANK_E: unit_on = two[BANK_E_BIT];
      default:     unit_on = 1'b1;
    endcase
  endfunction

  logic [31:0] run_one_reg;
  logic [31:0] run_two_reg;
  logic [31:0] sleep_one_reg;
  logic [31:0] sleep_two_reg;
  logic [31:0] deep_one_reg;
  logic [31:0] deep_two_reg;
  logic [31:0] run_cfg_reg;
  logic [31:0] irq_status_reg;
  logic [31:0] irq_mask_reg;
  logic [3:0]  fault_unit_reg;
  logic [31:0] gate_one_reg;
  logic [31:0] gate_two_reg;
  logic [31:0] eff_one_next;
  logic [31:0] eff_two_next;
  logic [31:0] rd_data_next;
  logic        rd_hit_next;
  logic        bus_req;
  logic        bus_wr;
  logic        fault_evt;
  logic        change_evt;
  logic [31:0] evt_vec;

  // A new request is taken only while no answer is out, so each cycle acks once.
  assign bus_req    = WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT && !WB_ERR_OUT;
  assign bus_wr     = bus_req && WB_WE_IN && rd_hit_next;
  assign fault_evt  = UNIT_ACCESS_IN && !unit_on(UNIT_SEL_IN, gate_one_reg, gate_two_reg);
  assign change_evt = (eff_one_next != gate_one_reg) || (eff_two_next != gate_two_reg);
  assign evt_vec    = ({31'h0, fault_evt} << EVT_FAULT_BIT)
                    | ({31'h0, change_evt} << EVT_CHANGE_BIT);

  // Read mux; reserved bits are never stored, so they read as zero.
  always_comb begin
    rd_hit_next  = 1'b1;
    rd_data_next = 32'h0000_0000;
    if (addr_hit(WB_ADR_IN, RUN_ONE_OFF)) begin
      rd_data_next = run_one_reg;
    end else if (addr_hit(WB_ADR_IN, RUN_TWO_OFF)) begin
      rd_data_next = run_two_reg;
    end else if (addr_hit(WB_ADR_IN, SLEEP_ONE_OFF)) begin
      rd_data_next = sleep_one_reg;
    end else if (addr_hit(WB_ADR_IN, SLEEP_TWO_OFF)) begin
      rd_data_next = sleep_two_reg;
    end else if (addr_hit(WB_ADR_IN, DEEP_ONE_OFF)) begin
      rd_data_next = deep_one_reg;
    end else if (addr_hit(WB_ADR_IN, DEEP_TWO_OFF)) begin
      rd_data_next = deep_two_reg;
    end else if (addr_hit(WB_ADR_IN, RUN_CFG_OFF)) begin
      rd_data_next = run_cfg_reg;
    end else if (addr_hit(WB_ADR_IN, IRQ_STATUS_OFF)) begin
      rd_data_next = irq_status_reg;
    end else if (addr_hit(WB_ADR_IN, IRQ_MASK_OFF)) begin
      rd_data_next = irq_mask_reg;
    end else if (addr_hit(WB_ADR_IN, FAULT_UNIT_OFF)) begin
      rd_data_next = {28'h000_0000, fault_unit_reg};
    end else begin
      rd_hit_next = 1'b0;
    end
  end

  // Bus answer: ack for mapped words, err for unmapped ones, each for one cycle.
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      WB_ACK_OUT <= 1'b0;
      WB_ERR_OUT <= 1'b0;
      WB_DAT_OUT <= 32'h0000_0000;
    end else begin
      WB_ACK_OUT <= bus_req && rd_hit_next;
      WB_ERR_OUT <= bus_req && !rd_hit_next;
      if (bus_req && !WB_WE_IN) begin
        WB_DAT_OUT <= rd_data_next;
      end
    end
  end

  // Gating words; only documented bits are writable, the rest stay zero.
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      run_one_reg   <= GATE_RESET;
      run_two_reg   <= GATE_RESET;
      sleep_one_reg <= GATE_RESET;
      sleep_two_reg <= GATE_RESET;
      deep_one_reg  <= GATE_RESET;
      deep_two_reg  <= GATE_RESET;
    end else if (bus_wr) begin
      if (addr_hit(WB_ADR_IN, RUN_ONE_OFF)) begin
        run_one_reg <= merge_write(run_one_reg, WB_DAT_IN, WB_SEL_IN, GROUP_ONE_MASK);
      end
      if (addr_hit(WB_ADR_IN, SLEEP_ONE_OFF)) begin
        sleep_one_reg <= merge_write(sleep_one_reg, WB_DAT_IN, WB_SEL_IN, GROUP_ONE_MASK);
      end
      if (addr_hit(WB_ADR_IN, DEEP_ONE_OFF)) begin
        deep_one_reg <= merge_write(deep_one_reg, WB_DAT_IN, WB_SEL_IN, GROUP_ONE_MASK);
      end
      if (addr_hit(WB_ADR_IN, RUN_TWO_OFF)) begin
        run_two_reg <= merge_write(run_two_reg, WB_DAT_IN, WB_SEL_IN, GROUP_TWO_MASK);
      end
      if (addr_hit(WB_ADR_IN, SLEEP_TWO_OFF)) begin
        sleep_two_reg <= merge_write(sleep_two_reg, WB_DAT_IN, WB_SEL_IN, GROUP_TWO_MASK);
      end
      if (addr_hit(WB_ADR_IN, DEEP_TWO_OFF)) begin
        deep_two_reg <= merge_write(deep_two_reg, WB_DAT_IN, WB_SEL_IN, GROUP_TWO_MASK);
      end
    end
  end

  // Run clock configuration holding the automatic gating select.
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      run_cfg_reg <= 32'h0000_0000;
    end else if (bus_wr && addr_hit(WB_ADR_IN, RUN_CFG_OFF)) begin
      run_cfg_reg <= merge_write(run_cfg_reg, WB_DAT_IN, WB_SEL_IN, RUN_CFG_MASK);
    end
  end

  // Interrupt mask.
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      irq_mask_reg <= 32'h0000_0000;
    end else if (bus_wr && addr_hit(WB_ADR_IN, IRQ_MASK_OFF)) begin
      irq_mask_reg <= merge_write(irq_mask_reg, WB_DAT_IN, WB_SEL_IN, IRQ_MASK_BITS);
    end
  end

  // Sticky events; write one clears, a same-cycle event wins so none is lost.
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      irq_status_reg <= 32'h0000_0000;
    end else begin
      if (bus_wr && addr_hit(WB_ADR_IN, IRQ_STATUS_OFF)) begin
        irq_status_reg <= (irq_status_reg
                          & ~merge_write(32'h0, WB_DAT_IN, WB_SEL_IN, IRQ_MASK_BITS))
                          | evt_vec;
      end else begin
        irq_status_reg <= irq_status_reg | evt_vec;
      end
    end
  end

  // Level interrupt, registered so the output comes straight from a flip-flop.
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      IRQ_OUT <= 1'b0;
    end else begin
      IRQ_OUT <= |(irq_status_reg & irq_mask_reg);
    end
  end

  // Mode-dependent choice of gating words.
  pcg_gate_select u_select (
    .mode_in      (POWER_MODE_IN),
    .auto_gate_in (run_cfg_reg[AUTO_GATE_BIT]),
    .run_one_in   (run_one_reg),
    .run_two_in   (run_two_reg),
    .sleep_one_in (sleep_one_reg),
    .sleep_two_in (sleep_two_reg),
    .deep_one_in  (deep_one_reg),
    .deep_two_in  (deep_two_reg),
    .eff_one_out  (eff_one_next),
    .eff_two_out  (eff_two_next)
  );

  // Applied enables lag the selected words by one cycle to keep outputs glitch free.
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      gate_one_reg <= GATE_RESET;
      gate_two_reg <= GATE_RESET;
    end else begin
      gate_one_reg <= eff_one_next;
      gate_two_reg <= eff_two_next;
    end
  end

  // Unit clock enables, one flip-flop each.
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      ANALOG_COMPARATOR_ZERO_GATE_OUT <= 1'b0;
      GENERAL_TIMER_TWO_GATE_OUT      <= 1'b0;
      GENERAL_TIMER_ONE_GATE_OUT      <= 1'b0;
      GENERAL_TIMER_ZERO_GATE_OUT     <= 1'b0;
      TWO_WIRE_GATE_OUT               <= 1'b0;
      SYNCHRONOUS_SERIAL_GATE_OUT     <= 1'b0;
      ASYNC_SERIAL_SECOND_GATE_OUT    <= 1'b0;
      ASYNC_SERIAL_FIRST_GATE_OUT     <= 1'b0;
      IO_BANK_E_GATE_OUT              <= 1'b0;
      IO_BANK_D_GATE_OUT              <= 1'b0;
      IO_BANK_C_GATE_OUT              <= 1'b0;
      IO_BANK_B_GATE_OUT              <= 1'b0;
      IO_BANK_A_GATE_OUT              <= 1'b0;
    end else begin
      ANALOG_COMPARATOR_ZERO_GATE_OUT <= eff_one_next[CMP_ZERO_BIT];
      GENERAL_TIMER_TWO_GATE_OUT      <= eff_one_next[TIMER2_BIT];
      GENERAL_TIMER_ONE_GATE_OUT      <= eff_one_next[TIMER1_BIT];
      GENERAL_TIMER_ZERO_GATE_OUT     <= eff_one_next[TIMER0_BIT];
      TWO_WIRE_GATE_OUT               <= eff_one_next[TWI_BIT];
      SYNCHRONOUS_SERIAL_GATE_OUT     <= eff_one_next[SYNC_BIT];
      ASYNC_SERIAL_SECOND_GATE_OUT    <= eff_one_next[ASYNC1_BIT];
      ASYNC_SERIAL_FIRST_GATE_OUT     <= eff_one_next[ASYNC0_BIT];
      IO_BANK_E_GATE_OUT              <= eff_two_next[BANK_E_BIT];
      IO_BANK_D_GATE_OUT              <= eff_two_next[BANK_D_BIT];
      IO_BANK_C_GATE_OUT              <= eff_two_next[BANK_C_BIT];
      IO_BANK_B_GATE_OUT              <= eff_two_next[BANK_B_BIT];
      IO_BANK_A_GATE_OUT              <= eff_two_next[BANK_A_BIT];
    end
  end

  // Access check against the enables the units actually see; faulted accesses never pass.
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      UNIT_GRANT_OUT <= 1'b0;
      UNIT_FAULT_OUT <= 1'b0;
      fault_unit_reg <= 4'h0;
    end else begin
      UNIT_GRANT_OUT <= UNIT_ACCESS_IN && !fault_evt;
      UNIT_FAULT_OUT <= fault_evt;
      if (fault_evt) begin
        fault_unit_reg <= UNIT_SEL_IN;
      end
    end
  end

  // Checks on the block's outputs and internal registers.
  AST_GATE_FOLLOWS_WORD: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    ASYNC_SERIAL_FIRST_GATE_OUT == gate_one_reg[ASYNC0_BIT]
    && IO_BANK_A_GATE_OUT == gate_two_reg[BANK_A_BIT])
    else $error("Gate output differs from applied enable word.");

  AST_FAULT_BLOCKS_ACCESS: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    UNIT_ACCESS_IN && !unit_on(UNIT_SEL_IN, gate_one_reg, gate_two_reg)
    |=> UNIT_FAULT_OUT && !UNIT_GRANT_OUT)
    else $error("Access to an unclocked unit was not faulted.");

  AST_CLOCKED_GRANTS: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    UNIT_ACCESS_IN && unit_on(UNIT_SEL_IN, gate_one_reg, gate_two_reg)
    |=> UNIT_GRANT_OUT && !UNIT_FAULT_OUT)
    else $error("Access to a clocked unit was not granted.");

  AST_RESET_GATES_OFF: assert property (@(posedge CLK_IN)
    $rose(RST_N_IN) |-> gate_one_reg == GATE_RESET && gate_two_reg == GATE_RESET
    && !TWO_WIRE_GATE_OUT)
    else $error("Gates not off right after reset.");

  AST_RUN_ONE_WRITE: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    bus_wr && addr_hit(WB_ADR_IN, RUN_ONE_OFF) && WB_SEL_IN == 4'hF
    |=> run_one_reg == ($past(WB_DAT_IN) & GROUP_ONE_MASK) && WB_ACK_OUT)
    else $error("Run group one write not stored.");

  AST_DEEP_TWO_WRITE: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    bus_wr && addr_hit(WB_ADR_IN, DEEP_TWO_OFF) && WB_SEL_IN == 4'hF
    |=> deep_two_reg == ($past(WB_DAT_IN) & GROUP_TWO_MASK))
    else $error("Deep-sleep group two write not stored.");

  AST_NO_AUTO_KEEPS_RUN: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    !run_cfg_reg[AUTO_GATE_BIT] ##1 !run_cfg_reg[AUTO_GATE_BIT]
    |-> gate_one_reg == $past(run_one_reg) && gate_two_reg == $past(run_two_reg))
    else $error("Low-power word used without automatic gating.");

  AST_SLEEP_USES_SLEEP_WORD: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    run_cfg_reg[AUTO_GATE_BIT] && POWER_MODE_IN == PCG_SLEEP
    |=> gate_one_reg == $past(sleep_one_reg) && gate_two_reg == $past(sleep_two_reg))
    else $error("Sleep word not applied in sleep with automatic gating.");

  AST_COMP_BIT_24: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    ##1 ANALOG_COMPARATOR_ZERO_GATE_OUT == $past(eff_one_next[24])
    && GENERAL_TIMER_TWO_GATE_OUT == $past(eff_one_next[18]))
    else $error("Comparator or timer two enable on wrong bit.");

  AST_RESERVED_ZERO: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    (run_one_reg & ~GROUP_ONE_MASK) == 32'h0 && (sleep_two_reg & ~GROUP_TWO_MASK) == 32'h0)
    else $error("Reserved gating bit became set.");

  AST_ACK_ONE_CYCLE: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    WB_ACK_OUT |=> !WB_ACK_OUT)
    else $error("Acknowledge held for more than one cycle.");

endmodule

// File: verilog/pcg_pkg.sv
// Purpose: Shared constants and types of the peripheral clock gating bank.
// Assumes: Registers sit on a classic Wishbone slave with 32-bit data and byte addresses.
// Notes:   Offsets are byte addresses; only the low twelve address bits are decoded.
package pcg_pkg;

  // Address width decoded by the slave.
  localparam int ADDR_W = 12;

  // Gating register offsets.
  localparam logic [11:0] RUN_ONE_OFF   = 12'h104;
  localparam logic [11:0] RUN_TWO_OFF   = 12'h108;
  localparam logic [11:0] SLEEP_ONE_OFF = 12'h114;
  localparam logic [11:0] SLEEP_TWO_OFF = 12'h118;
  localparam logic [11:0] DEEP_ONE_OFF  = 12'h124;
  localparam logic [11:0] DEEP_TWO_OFF  = 12'h128;

  // Control, interrupt and diagnostic registers.
  localparam logic [11:0] RUN_CFG_OFF    = 12'h200;
  localparam logic [11:0] IRQ_STATUS_OFF = 12'h204;
  localparam logic [11:0] IRQ_MASK_OFF   = 12'h208;
  localparam logic [11:0] FAULT_UNIT_OFF = 12'h20C;

  // Writable bits and the gating reset value; every other bit is read-only and reads as zero.
  localparam logic [31:0] GROUP_ONE_MASK = 32'h0107_1013;
  localparam logic [31:0] GROUP_TWO_MASK = 32'h0000_001F;
  localparam logic [31:0] RUN_CFG_MASK   = 32'h0000_0001;
  localparam logic [31:0] IRQ_MASK_BITS  = 32'h0000_0003;
  localparam logic [31:0] GATE_RESET     = 32'h0000_0000;

  // Field positions.
  localparam int CMP_ZERO_BIT = 24;
  localparam int TIMER2_BIT = 18;
  localparam int TIMER1_BIT = 17;
  localparam int TIMER0_BIT = 16;
  localparam int TWI_BIT    = 12;
  localparam int SYNC_BIT   = 4;
  localparam int ASYNC1_BIT = 1;
  localparam int ASYNC0_BIT = 0;
  localparam int BANK_E_BIT = 4;
  localparam int BANK_D_BIT = 3;
  localparam int BANK_C_BIT = 2;
  localparam int BANK_B_BIT = 1;
  localparam int BANK_A_BIT = 0;
  localparam int AUTO_GATE_BIT = 0;
  localparam int EVT_FAULT_BIT  = 0;
  localparam int EVT_CHANGE_BIT = 1;

  // Unit numbers carried on the access-check port.
  localparam logic [3:0] UNIT_ASYNC0 = 4'h0;
  localparam logic [3:0] UNIT_ASYNC1 = 4'h1;
  localparam logic [3:0] UNIT_SYNC   = 4'h2;
  localparam logic [3:0] UNIT_TWI    = 4'h3;
  localparam logic [3:0] UNIT_TIMER0 = 4'h4;
  localparam logic [3:0] UNIT_TIMER1 = 4'h5;
  localparam logic [3:0] UNIT_TIMER2 = 4'h6;
  localparam logic [3:0] UNIT_CMP_ZERO = 4'h7;
  localparam logic [3:0] UNIT_BANK_A = 4'h8;
  localparam logic [3:0] UNIT_BANK_B = 4'h9;
  localparam logic [3:0] UNIT_BANK_C = 4'hA;
  localparam logic [3:0] UNIT_BANK_D = 4'hB;
  localparam logic [3:0] UNIT_BANK_E = 4'hC;

  // Operating mode, Gray coded along run, sleep, deep sleep.
  typedef enum logic [1:0] {
    PCG_RUN   = 2'h0,
    PCG_SLEEP = 2'h1,
    PCG_DEEP  = 2'h3
  } pcg_mode_type;

endpackage
